// [verif/asu_core_monitor.sv]
// checker: port-level assertions for the serial unit
`timescale 1ns/1ps
module asu_core_monitor (
  input wire logic clk, // system clock
  input wire logic rst, // sync reset
  input wire logic [4:0] avs_address, // byte address
  input wire logic avs_read, // read request
  input wire logic avs_write, // write request
  input wire logic [31:0] avs_writedata, // write data
  input wire logic [3:0] avs_byteenable, // lanes
  input wire logic [31:0] avs_readdata, // read data
  input wire logic avs_waitrequest, // stall
  input wire logic link_clk_i, // clock line in
  input wire logic link_clk_o, // clock line out
  input wire logic link_clk_oe_n, // clock enable, low drives
  input wire logic link_dat_i, // data line in
  input wire logic link_dat_o, // data line out
  input wire logic link_dat_oe_n, // data enable, low drives
  input wire logic irq, // interrupt
  input wire logic wake // wake request
);
  // one domain, so clock and reset are set once
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  ////////////////////////////////////////////////////////////
  property p_rst_quiet;
    @(posedge clk) disable iff (1'b0)
      rst |=> link_clk_oe_n && link_dat_oe_n && !irq && !wake;
  endproperty
  a_rst_quiet: assert property (p_rst_quiet) else $error("drivers on after reset");
  property p_wait_start;
    $rose(avs_read) |-> avs_waitrequest;
  endproperty
  a_wait_start: assert property (p_wait_start) else $error("read not stalled");
  property p_wait_one;
    (avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest;
  endproperty
  a_wait_one: assert property (p_wait_one) else $error("stall too long");
  // readdata shows a value only in the cycle after a read is taken
  property p_rd_stand;
    !$past(avs_read && avs_waitrequest) |-> avs_readdata == asu_pkg::WORD_ZERO;
  endproperty
  a_rd_stand: assert property (p_rd_stand) else $error("read data moved");
  property p_wr_zero;
    avs_write && avs_waitrequest |=> avs_readdata == asu_pkg::WORD_ZERO;
  endproperty
  a_wr_zero: assert property (p_wr_zero) else $error("read data after write");
  property p_rd_upper;
    avs_read && !avs_waitrequest |-> avs_readdata[31:8] == 24'h00_0000;
  endproperty
  a_rd_upper: assert property (p_rd_upper) else $error("upper bits set");
  property p_unmapped;
    avs_read && avs_waitrequest && (avs_address[1:0] != 2'h0)
      |=> avs_readdata == asu_pkg::WORD_ZERO;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped read data");
  property p_clk_driven;
    $changed(link_clk_o) |-> !link_clk_oe_n || !$past(link_clk_oe_n);
  endproperty
  a_clk_driven: assert property (p_clk_driven) else $error("clock moved undriven");
  // clock driver direction follows mode bits only
  property p_oe_by_write;
    !$past(avs_write) && !$past(avs_write, 2) |-> $stable(link_clk_oe_n);
  endproperty
  a_oe_by_write: assert property (p_oe_by_write) else $error("clock enable moved");
  c_master_clk: cover property ($rose(link_clk_o));
  c_wake: cover property ($rose(wake));
  c_irq: cover property ($rose(irq));
endmodule // asu_core_monitor

bind asu_core asu_core_monitor u_asu_core_monitor (.clk(clk), .rst(rst),
  .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
  .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
  .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
  .link_clk_i(link_clk_i), .link_clk_o(link_clk_o), .link_clk_oe_n(link_clk_oe_n),
  .link_dat_i(link_dat_i), .link_dat_o(link_dat_o), .link_dat_oe_n(link_dat_oe_n),
  .irq(irq), .wake(wake));

// [verif/asu_core_tb.sv]
// testbench: register-level tests of the serial unit with a link partner
`timescale 1ns/1ps
`define CHK(g, e) begin checks++; if ((g) !== (e)) begin fails++; $display("Error %0t: got %h exp %h", $time, (g), (e)); end end
module asu_core_tb;
  logic clk, rst, avs_read, avs_write, link_clk_o, link_clk_oe_n;
  logic link_dat_o, link_dat_oe_n, irq, wake, avs_waitrequest;
  logic [4:0] avs_address;
  logic [31:0] avs_writedata, avs_readdata, v;
  logic [8:0] d;
  wire link_clk;
  wire link_dat;
  int fails, checks, rises, cyc, r0;
  asu_core u_asu_core (.clk(clk), .rst(rst), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_byteenable(4'h1), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .link_clk_i(link_clk), .link_clk_o(link_clk_o), .link_clk_oe_n(link_clk_oe_n),
    .link_dat_i(link_dat), .link_dat_o(link_dat_o), .link_dat_oe_n(link_dat_oe_n),
    .irq(irq), .wake(wake));
  asu_link_partner u_asu_link_partner (.dut_clk_o(link_clk_o), .dut_clk_oe_n(link_clk_oe_n),
    .dut_dat_o(link_dat_o), .dut_dat_oe_n(link_dat_oe_n), .link_clk(link_clk),
    .link_dat(link_dat));
  ////////////////////////////////////////////////////////////
  // 20 MHz system clock
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  // count clock line pulses, whoever drives them
  always @(posedge link_clk) rises++;
  // hang guard, far above the expected thousand or so cycles
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      fails++;
      close_out();
    end
  end
  task automatic close_out();
    $display("checks %0d fails %0d", checks, fails);
    if (fails == 0 && checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  // avalon write: hold until waitrequest is sampled low at a rising edge
  task automatic wr(input logic [4:0] a, input logic [7:0] x);
    @(posedge clk);
    avs_address <= a;
    avs_writedata <= {24'h00_0000, x};
    avs_write <= 1'b1;
    @(posedge clk);
    while (avs_waitrequest !== 1'b0) @(posedge clk);
    avs_write <= 1'b0;
  endtask
  // avalon read: data taken at the edge that sees waitrequest low
  task automatic rd(input logic [4:0] a, output logic [31:0] x);
    @(posedge clk);
    avs_address <= a;
    avs_read <= 1'b1;
    @(posedge clk);
    while (avs_waitrequest !== 1'b0) @(posedge clk);
    x = avs_readdata;
    avs_read <= 1'b0;
  endtask
  // poll a flag bit, bounded
  task automatic wait_flag(input int b);
    logic [31:0] f;
    for (int i = 0; i < 400; i++) begin
      rd(asu_pkg::ADDR_FLAGS, f);
      if (f[b] === 1'b1) break;
    end
  endtask
  ////////////////////////////////////////////////////////////
  initial begin
    rst = 1'b1;
    avs_address = 5'h00;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_writedata = 32'h0000_0000;
    {fails, checks, r0} = '0;
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    // reset values and an unmapped address
    rd(asu_pkg::ADDR_RX_STATUS, v); `CHK(v[7:0], asu_pkg::RS_RESET)
    rd(asu_pkg::ADDR_TX_STATUS, v); `CHK(v[7:0], asu_pkg::TS_RESET)
    rd(5'h01, v); `CHK(v, asu_pkg::WORD_ZERO)
    // master single receive: one character of clocks, then stop
    wr(asu_pkg::ADDR_BAUD, 8'h07);
    wr(asu_pkg::ADDR_TX_STATUS, 8'h94);
    wr(asu_pkg::ADDR_RX_STATUS, 8'h80);
    r0 = rises;
    fork u_asu_link_partner.feed(9'h0a5, 8); join_none
    wr(asu_pkg::ADDR_RX_STATUS, 8'ha0);
    `CHK(link_clk_oe_n, 1'b0)
    wait_flag(asu_pkg::FL_RX);
    rd(asu_pkg::ADDR_RX_STATUS, v); `CHK(v[7:0], 8'h80)
    rd(asu_pkg::ADDR_RX_DATA, v); `CHK(v[7:0], 8'ha5)
    repeat (100) @(posedge clk);
    `CHK(rises - r0, 8)
    rd(asu_pkg::ADDR_FLAGS, v); `CHK(v[asu_pkg::FL_RX], 1'b0)
    // slave nine-bit receive in sleep, then overrun
    wr(asu_pkg::ADDR_TX_STATUS, 8'h10);
    wr(asu_pkg::ADDR_ENABLES, 8'h20);
    wr(asu_pkg::ADDR_CORE, 8'h06);
    wr(asu_pkg::ADDR_RX_STATUS, 8'hd0);
    `CHK(link_clk_oe_n, 1'b1)
    u_asu_link_partner.send(9'h1c3, 9);
    repeat (10) @(posedge clk);
    `CHK(wake, 1'b1)
    `CHK(irq, 1'b0)
    u_asu_link_partner.send(9'h05a, 9);
    u_asu_link_partner.send(9'h1ff, 9);
    repeat (10) @(posedge clk);
    rd(asu_pkg::ADDR_RX_STATUS, v); `CHK(v[7:0], 8'hd3)
    rd(asu_pkg::ADDR_RX_DATA, v); `CHK(v[7:0], 8'hc3)
    rd(asu_pkg::ADDR_RX_STATUS, v); `CHK(v[7:0], 8'hd2)
    rd(asu_pkg::ADDR_RX_DATA, v); `CHK(v[7:0], 8'h5a)
    rd(asu_pkg::ADDR_FLAGS, v); `CHK(v[asu_pkg::FL_RX], 1'b0)
    wr(asu_pkg::ADDR_RX_STATUS, 8'hc0);
    rd(asu_pkg::ADDR_RX_STATUS, v); `CHK(v[asu_pkg::RS_OVERRUN], 1'b0)
    // slave receives a character with single receive as its only enable
    wr(asu_pkg::ADDR_RX_STATUS, 8'ha0);
    u_asu_link_partner.send(9'h03c, 8);
    repeat (10) @(posedge clk);
    rd(asu_pkg::ADDR_RX_DATA, v); `CHK(v[7:0], 8'h3c)
    // slave transmit of two queued characters in sleep
    wr(asu_pkg::ADDR_RX_STATUS, 8'h80);
    wr(asu_pkg::ADDR_TX_STATUS, 8'h30);
    wr(asu_pkg::ADDR_ENABLES, 8'h10);
    wr(asu_pkg::ADDR_CORE, 8'h07);
    wr(asu_pkg::ADDR_TX_HOLD, 8'h96);
    wr(asu_pkg::ADDR_TX_HOLD, 8'h3b);
    rd(asu_pkg::ADDR_FLAGS, v); `CHK(v[asu_pkg::FL_TX], 1'b0)
    `CHK(wake, 1'b0)
    `CHK(link_dat_oe_n, 1'b0)
    u_asu_link_partner.recv(8, d); `CHK(d[7:0], 8'h96)
    repeat (10) @(posedge clk);
    `CHK(wake, 1'b1)
    `CHK(irq, 1'b1)
    rd(asu_pkg::ADDR_FLAGS, v); `CHK(v[asu_pkg::FL_TX], 1'b1)
    u_asu_link_partner.recv(8, d); `CHK(d[7:0], 8'h3b)
    // master mode makes no clocks while asleep
    wr(asu_pkg::ADDR_CORE, 8'h04);
    wr(asu_pkg::ADDR_RX_STATUS, 8'h80);
    wr(asu_pkg::ADDR_TX_STATUS, 8'h94);
    r0 = rises;
    wr(asu_pkg::ADDR_RX_STATUS, 8'h90);
    repeat (200) @(posedge clk);
    `CHK(rises - r0, 0)
    close_out();
  end
endmodule // asu_core_tb

// [verif/asu_link_partner.sv]
// partner: far-end device on the shared clock and data lines
`timescale 1ns/1ps
module asu_link_partner (
  input wire logic dut_clk_o, // unit clock out
  input wire logic dut_clk_oe_n, // unit drives clock when low
  input wire logic dut_dat_o, // unit data out
  input wire logic dut_dat_oe_n, // unit drives data when low
  output wire link_clk, // resolved clock line
  output wire link_dat // resolved data line
);
  logic p_clk;
  logic p_dat;
  // line level from the unit's enables; the partner drives when the unit releases
  assign link_clk = dut_clk_oe_n ? p_clk : dut_clk_o;
  assign link_dat = dut_dat_oe_n ? p_dat : dut_dat_o;
  // clock stands low between frames
  initial begin
    p_clk = 1'b0;
    p_dat = 1'b1;
  end
  ////////////////////////////////////////////////////////////
  // external clock, data on leading edge
  task automatic send(input logic [8:0] d, input int n);
    // step off the system clock edge, the line is asynchronous to it
    #10;
    for (int i = 0; i < n; i++) begin
      p_clk = 1'b1;
      p_dat = d[i];
      #200;
      p_clk = 1'b0;
      #200;
    end
    // released line shows the inverse, never a stale bit
    p_dat = ~d[n-1];
  endtask
  // clock out the unit's data, sample mid low phase
  task automatic recv(input int n, output logic [8:0] d);
    d = 9'h000;
    // step off the system clock edge, the line is asynchronous to it
    #10;
    for (int i = 0; i < n; i++) begin
      p_clk = 1'b1;
      #200;
      p_clk = 1'b0;
      #100;
      d[i] = link_dat;
      #100;
    end
  endtask
  // follow the master clock, change on leading edge
  task automatic feed(input logic [8:0] d, input int n);
    for (int i = 0; i < n; i++) begin
      @(posedge link_clk);
      p_dat = d[i];
    end
    @(negedge link_clk);
    p_dat = ~d[n-1];
  endtask
endmodule // asu_link_partner

// [verilog/asu_core.sv]
// file: synchronous-mode serial unit with avalon register slave
`timescale 1ns/1ps
module asu_core (
  input wire logic clk,                 // system clock, 20 MHz
  input wire logic rst,                 // sync reset, active high
  input wire logic [4:0] avs_address,   // byte address
  input wire logic avs_read,            // read request
  input wire logic avs_write,           // write request
  input wire logic [31:0] avs_writedata, // write data
  input wire logic [3:0] avs_byteenable, // byte lanes
  output logic [31:0] avs_readdata,     // read data
  output logic avs_waitrequest,         // stall
  input wire logic link_clk_i,          // clock line in
  output logic link_clk_o,              // clock line out
  output logic link_clk_oe_n,           // clock driver enable, low drives
  input wire logic link_dat_i,          // data line in
  output logic link_dat_o,              // data line out
  output logic link_dat_oe_n,           // data driver enable, low drives
  output logic irq,                     // interrupt to processor
  output logic wake                     // wake request during sleep
);
  logic [7:0] rs_r, rs_nxt, ts_r, ts_nxt, en_r, en_nxt, baud_r, baud_nxt;
  logic [2:0] core_r, core_nxt;
  logic [8:0] hold_r, hold_nxt, tsr_r, tsr_nxt, rsr_r, rsr_nxt;
  logic hold_full_r, hold_full_nxt, tsr_busy_r, tsr_busy_nxt;
  logic [3:0] bits_r, bits_nxt;
  logic [7:0] div_r, div_nxt;
  logic mclk_r, mclk_nxt, ack_r, ack_nxt, dat_o_r, dat_o_nxt, clk_prev_r;
  logic [31:0] rdata_r, rdata_nxt;
  logic sclk, sdat, push, pop, flush;
  logic [8:0] head;
  logic [1:0] count;

  // the link runs on the system clock only: slave edges are found by oversampling the
  // synchronised clock line, so each link clock phase must last at least four clk cycles
  // (two synchroniser flops, the edge detector and the update of the shifter)

  //////////////////////////////////////////////////////////////////////////
  // link pin synchronisers
  // pins synchronised
  asu_sync u_sync_clk (.clk(clk), .rst(rst), .din(link_clk_i), .dout(sclk));
  asu_sync u_sync_dat (.clk(clk), .rst(rst), .din(link_dat_i), .dout(sdat));

  // the fifo takes the shifter's next value: the last bit lands in the same cycle as
  // the push, so the registered shifter would still miss it
  asu_rx_fifo u_fifo (
    .clk(clk), .rst(rst), .flush(flush), .push(push), .wdata(rsr_nxt),
    .pop(pop), .head(head), .count(count)
  );

  // character length in link clocks for the selected width
  function automatic logic [3:0] char_len(input logic nine);
    char_len = nine ? asu_pkg::LEN_NINE : asu_pkg::LEN_EIGHT;
  endfunction

  // register select on the full byte address
  function automatic logic hit(input logic [4:0] a, input logic [4:0] reg_a);
    hit = (a == reg_a);
  endfunction

  // mode decode
  logic port_on, sync_on, master, slave, rx_dir, sleeping, rx_run, tx_run;
  logic edge_lead, edge_trail, wr, rd;
  always_comb begin
    port_on = rs_r[asu_pkg::RS_PORT_EN];
    sync_on = ts_r[asu_pkg::TS_SYNC];
    master = port_on && sync_on && ts_r[asu_pkg::TS_CLK_MASTER];
    slave = port_on && sync_on && !ts_r[asu_pkg::TS_CLK_MASTER];
    rx_dir = rs_r[asu_pkg::RS_SINGLE] || rs_r[asu_pkg::RS_CONT];
    sleeping = core_r[asu_pkg::CC_SLEEP];
    // slave listens on either enable, single receive never stops it
    if (slave) begin
      rx_run = rx_dir;
    end else begin
      rx_run = master && rx_dir && !sleeping;
    end
    // after an overrun reception halts until the error is cleared
    rx_run = rx_run && !rs_r[asu_pkg::RS_OVERRUN];
    tx_run = ts_r[asu_pkg::TS_TX_EN] && !rx_dir && (slave || (master && !sleeping));
    // master edges come from its divider, slave edges from the synchronised line
    edge_lead = master ? (div_r == baud_r && !mclk_r) : (sclk && !clk_prev_r);
    edge_trail = master ? (div_r == baud_r && mclk_r) : (!sclk && clk_prev_r);
    // a request is taken only in its first cycle
    wr = avs_write && !ack_r;
    rd = avs_read && !ack_r;
  end

  //////////////////////////////////////////////////////////////////////////
  // next state for registers, shifters and bus answer
  always_comb begin
    rs_nxt = rs_r;
    ts_nxt = ts_r;
    en_nxt = en_r;
    baud_nxt = baud_r;
    core_nxt = core_r;
    hold_nxt = hold_r;
    hold_full_nxt = hold_full_r;
    tsr_nxt = tsr_r;
    tsr_busy_nxt = tsr_busy_r;
    rsr_nxt = rsr_r;
    bits_nxt = bits_r;
    div_nxt = div_r;
    mclk_nxt = mclk_r;
    dat_o_nxt = dat_o_r;
    push = 1'b0;
    pop = 1'b0;
    flush = 1'b0;
    ack_nxt = (avs_read || avs_write) && !ack_r;
    rdata_nxt = asu_pkg::WORD_ZERO;

    // register writes, low byte lane only
    // the upper lanes carry nothing, every register takes at most eight data bits
    if (wr && avs_byteenable[0]) begin
      if (hit(avs_address, asu_pkg::ADDR_RX_STATUS)) begin
        rs_nxt = {avs_writedata[7:3], rs_r[2:0]};
      end
      if (hit(avs_address, asu_pkg::ADDR_TX_STATUS)) begin
        ts_nxt = {avs_writedata[7:4], 1'b0, avs_writedata[2], ts_r[1], avs_writedata[0]};
      end
      if (hit(avs_address, asu_pkg::ADDR_ENABLES)) en_nxt = avs_writedata[7:0];
      if (hit(avs_address, asu_pkg::ADDR_BAUD)) baud_nxt = avs_writedata[7:0];
      if (hit(avs_address, asu_pkg::ADDR_CORE)) core_nxt = avs_writedata[2:0];
      if (hit(avs_address, asu_pkg::ADDR_TX_HOLD) && !hold_full_r) begin
        hold_nxt = {ts_r[asu_pkg::TS_NINTH], avs_writedata[7:0]};
        hold_full_nxt = 1'b1;
      end
    end

    // reads; data read pops the fifo
    // status bit 0 shows the ninth bit of the fifo head, not a stored copy
    if (rd) begin
      case (avs_address)
        asu_pkg::ADDR_RX_STATUS: rdata_nxt = {24'h00_0000, rs_r[7:1], head[8]};
        asu_pkg::ADDR_TX_STATUS: rdata_nxt = {24'h00_0000, ts_r};
        asu_pkg::ADDR_RX_DATA: begin
          rdata_nxt = {24'h00_0000, head[7:0]};
          pop = 1'b1;
        end
        asu_pkg::ADDR_FLAGS: rdata_nxt = {26'h000_0000, count != 2'h0, !hold_full_r, 4'h0};
        asu_pkg::ADDR_ENABLES: rdata_nxt = {24'h00_0000, en_r};
        asu_pkg::ADDR_BAUD: rdata_nxt = {24'h00_0000, baud_r};
        asu_pkg::ADDR_CORE: rdata_nxt = {29'h0000_0000, core_r};
        default: rdata_nxt = asu_pkg::WORD_ZERO;
      endcase
    end

    // master clock divider, halts when idle so the line rests low between characters
    if (master && (rx_run || tx_run && (tsr_busy_r || hold_full_r))) begin
      div_nxt = (div_r == baud_r) ? asu_pkg::BYTE_ZERO : div_r + 8'h01;
      if (div_r == baud_r) mclk_nxt = !mclk_r;
    end else begin
      div_nxt = asu_pkg::BYTE_ZERO;
      mclk_nxt = 1'b0;
    end

    // reload shifter, flag follows holding register
    if (tx_run && !tsr_busy_r && hold_full_r) begin
      tsr_nxt = hold_r;
      tsr_busy_nxt = 1'b1;
      hold_full_nxt = 1'b0;
      bits_nxt = asu_pkg::CNT_ZERO;
      // bit 0 goes out at once, before the far end's first edge
      dat_o_nxt = hold_r[0];
    end else if (tx_run && tsr_busy_r) begin
      // shifter steps on link clock edges, master and slave alike
      if (edge_trail) begin
        tsr_nxt = {1'b0, tsr_r[8:1]};
        bits_nxt = bits_r + asu_pkg::CNT_ONE;
        if (bits_r + asu_pkg::CNT_ONE == char_len(ts_r[asu_pkg::TS_NINE])) begin
          tsr_busy_nxt = 1'b0;
        end
      end
      if (edge_lead && bits_r != asu_pkg::CNT_ZERO) dat_o_nxt = tsr_r[0];
    end

    if (rx_run && edge_trail) begin
      rsr_nxt = {sdat, rsr_r[8:1]};
      bits_nxt = bits_r + asu_pkg::CNT_ONE;
      if (bits_r + asu_pkg::CNT_ONE == char_len(rs_r[asu_pkg::RS_NINE])) begin
        bits_nxt = asu_pkg::CNT_ZERO;
        if (!rs_r[asu_pkg::RS_NINE]) rsr_nxt = {1'b0, sdat, rsr_r[8:2]};
        // a full fifo keeps both characters; the new one is dropped
        // overrun when full
        if (count == asu_pkg::FIFO_DEPTH && !pop) begin
          rs_nxt[asu_pkg::RS_OVERRUN] = 1'b1;
        end else begin
          push = 1'b1;
        end
        if (master && !rs_r[asu_pkg::RS_CONT]) rs_nxt[asu_pkg::RS_SINGLE] = 1'b0;
      end
    end

    // partial character dropped when receive stops
    if (!rx_run && !tx_run) bits_nxt = asu_pkg::CNT_ZERO;

    // overrun cleared by continuous receive off
    if (!rs_nxt[asu_pkg::RS_CONT]) rs_nxt[asu_pkg::RS_OVERRUN] = 1'b0;

    // port disable clears overrun, holding register, shifter and fifo; control registers keep their values
    // queued and half-shifted characters are dropped as well
    if (!rs_nxt[asu_pkg::RS_PORT_EN]) begin
      rs_nxt[asu_pkg::RS_OVERRUN] = 1'b0;
      hold_full_nxt = 1'b0;
      tsr_busy_nxt = 1'b0;
      bits_nxt = asu_pkg::CNT_ZERO;
      flush = 1'b1;
      push = 1'b0;
    end

    // shift empty mirrors the shifter after this cycle's load or finish
    ts_nxt[asu_pkg::TS_SHIFT_EMPTY] = !tsr_busy_nxt;
  end

  //////////////////////////////////////////////////////////////////////////
  // register stage
  always_ff @(posedge clk) begin
    if (rst) begin
      rs_r <= asu_pkg::RS_RESET;
      ts_r <= asu_pkg::TS_RESET;
      en_r <= asu_pkg::BYTE_ZERO;
      baud_r <= asu_pkg::BYTE_ZERO;
      core_r <= 3'h0;
      hold_r <= 9'h000;
      hold_full_r <= 1'b0;
      tsr_r <= 9'h000;
      tsr_busy_r <= 1'b0;
      rsr_r <= 9'h000;
      bits_r <= asu_pkg::CNT_ZERO;
      div_r <= asu_pkg::BYTE_ZERO;
      mclk_r <= 1'b0;
      ack_r <= 1'b0;
      dat_o_r <= 1'b0;
      clk_prev_r <= 1'b0;
      rdata_r <= asu_pkg::WORD_ZERO;
    end else begin
      rs_r <= rs_nxt;
      ts_r <= ts_nxt;
      en_r <= en_nxt;
      baud_r <= baud_nxt;
      core_r <= core_nxt;
      hold_r <= hold_nxt;
      hold_full_r <= hold_full_nxt;
      tsr_r <= tsr_nxt;
      tsr_busy_r <= tsr_busy_nxt;
      rsr_r <= rsr_nxt;
      bits_r <= bits_nxt;
      div_r <= div_nxt;
      mclk_r <= mclk_nxt;
      ack_r <= ack_nxt;
      dat_o_r <= dat_o_nxt;
      clk_prev_r <= sclk;
      rdata_r <= rdata_nxt;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // outputs; flag levels come from fifo count and holding register state
  logic rx_flag, tx_flag, pend;
  always_comb begin
    // flags are levels: they clear by themselves when the cause goes away
    // receive flag while unread characters
    rx_flag = count != 2'h0;
    tx_flag = !hold_full_r;
    pend = (rx_flag && en_r[asu_pkg::FL_RX]) || (tx_flag && en_r[asu_pkg::FL_TX]
           && ts_r[asu_pkg::TS_TX_EN]);
    wake = sleeping && pend && core_r[asu_pkg::CC_PERIPH];
    irq = pend && core_r[asu_pkg::CC_PERIPH] && core_r[asu_pkg::CC_GLOBAL];
  end

  // one wait cycle per request; read data come from a flop
  assign avs_waitrequest = (avs_read || avs_write) && !ack_r;
  assign avs_readdata = rdata_r;
  assign link_clk_o = mclk_r;
  assign link_clk_oe_n = !master;
  assign link_dat_o = dat_o_r;
  assign link_dat_oe_n = !tx_run;
endmodule // asu_core

// [verilog/asu_pkg.sv]
// package: register map, field positions and constants of the addressable serial unit
package asu_pkg;
  // register byte addresses on the avalon slave (word aligned)
  localparam logic [4:0] ADDR_RX_STATUS = 5'h00;   // receive_status_control
  localparam logic [4:0] ADDR_TX_STATUS = 5'h04;   // transmit_status_control
  localparam logic [4:0] ADDR_RX_DATA = 5'h08;     // receive_data_register
  localparam logic [4:0] ADDR_TX_HOLD = 5'h0c;     // transmit_holding_register
  localparam logic [4:0] ADDR_FLAGS = 5'h10;       // peripheral_flags_one
  localparam logic [4:0] ADDR_ENABLES = 5'h14;     // peripheral_enables_one
  localparam logic [4:0] ADDR_BAUD = 5'h18;        // baud_divisor
  localparam logic [4:0] ADDR_CORE = 5'h1c;        // core control: global enable, sleep
  // receive_status_control bits
  localparam int RS_PORT_EN = 7;
  localparam int RS_NINE = 6;
  localparam int RS_SINGLE = 5;
  localparam int RS_CONT = 4;
  localparam int RS_ADDR_DET = 3;
  localparam int RS_FRAMING = 2;
  localparam int RS_OVERRUN = 1;
  localparam int RS_NINTH = 0;
  // transmit_status_control bits
  localparam int TS_CLK_MASTER = 7;
  localparam int TS_NINE = 6;
  localparam int TS_TX_EN = 5;
  localparam int TS_SYNC = 4;
  localparam int TS_BAUD_HI = 2;
  localparam int TS_SHIFT_EMPTY = 1;
  localparam int TS_NINTH = 0;
  // flag / enable bit positions
  localparam int FL_RX = 5;
  localparam int FL_TX = 4;
  // core control bits
  localparam int CC_GLOBAL = 0;
  localparam int CC_PERIPH = 1;
  localparam int CC_SLEEP = 2;
  // reset values
  localparam logic [7:0] RS_RESET = 8'h00;
  localparam logic [7:0] TS_RESET = 8'h02;
  localparam logic [7:0] BYTE_ZERO = 8'h00;
  localparam logic [31:0] WORD_ZERO = 32'h0000_0000;
  // character lengths
  localparam logic [3:0] LEN_EIGHT = 4'h8;
  localparam logic [3:0] LEN_NINE = 4'h9;
  localparam logic [3:0] CNT_ZERO = 4'h0;
  localparam logic [3:0] CNT_ONE = 4'h1;
  // fifo depth
  localparam logic [1:0] FIFO_DEPTH = 2'h2;
endpackage

// [verilog/asu_rx_fifo.sv]
// file: two-entry receive character fifo with registered head
`timescale 1ns/1ps
module asu_rx_fifo (
  input wire logic clk,          // system clock
  input wire logic rst,          // sync reset, active high
  input wire logic flush,        // drop all entries
  input wire logic push,         // store a character
  input wire logic [8:0] wdata,  // character to store
  input wire logic pop,          // drop head entry
  output logic [8:0] head,       // registered head character
  output logic [1:0] count       // entries held
);
  logic [8:0] mem_r [2];
  logic [8:0] mem_nxt [2];
  logic [1:0] count_r, count_nxt;
  logic [8:0] head_r, head_nxt;

  //////////////////////////////////////////////////////////////////////////
  // next state: push refused when full, pop and push may coincide
  always_comb begin
    logic do_push;
    do_push = push && (count_r != asu_pkg::FIFO_DEPTH || pop);
    mem_nxt = mem_r;
    count_nxt = count_r;
    if (flush) begin
      count_nxt = 2'h0;
    end else begin
      if (pop && count_r != 2'h0) begin
        mem_nxt[0] = mem_r[1];
        count_nxt = count_nxt - 2'h1;
      end
      if (do_push) begin
        mem_nxt[count_nxt[0]] = wdata;
        count_nxt = count_nxt + 2'h1;
      end
    end
    head_nxt = (count_nxt == 2'h0) ? 9'h000 : mem_nxt[0];
  end

  // register stage; head comes out of a flop
  always_ff @(posedge clk) begin
    if (rst) begin
      mem_r[0] <= 9'h000;
      mem_r[1] <= 9'h000;
      count_r <= 2'h0;
      head_r <= 9'h000;
    end else begin
      mem_r <= mem_nxt;
      count_r <= count_nxt;
      head_r <= head_nxt;
    end
  end

  assign head = head_r;
  assign count = count_r;
endmodule // asu_rx_fifo

// [verilog/asu_sync.sv]
// file: two-flop synchroniser for link pins
`timescale 1ns/1ps
module asu_sync (
  input wire logic clk,      // system clock
  input wire logic rst,      // sync reset
  input wire logic din,      // asynchronous level
  output logic dout          // synchronised level
);
  logic meta_r, sync_r;

  // first flop feeds only the second
  always_ff @(posedge clk) begin
    if (rst) begin
      meta_r <= 1'b0;
      sync_r <= 1'b0;
    end else begin
      meta_r <= din;
      sync_r <= meta_r;
    end
  end

  assign dout = sync_r;
endmodule // asu_sync
